// ===== bench/cepc_regs_assertions.sv
/*
 * Port assertions for the channel enable and power register bank.
 * Assumes write address and data are offered together by the master.
 */
module cepc_regs_assertions
(
	// Clock and reset
	input wire logic                 clk_sys,
	input wire logic                 rst,
	// Write channels
	input wire logic                 s_axi_awvalid,
	input wire logic                 s_axi_awready,
	input wire logic [9:0]           s_axi_awaddr,
	input wire logic                 s_axi_wvalid,
	input wire logic                 s_axi_wready,
	input wire logic [31:0]          s_axi_wdata,
	input wire logic [3:0]           s_axi_wstrb,
	// Controls
	input wire cepc_pkg::cepc_ctrl_s ctrl
);
	// ****************************************
	// Write decode
	// ****************************************
	wire logic       hs  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& s_axi_wstrb[0];
	wire logic       w73 = hs && s_axi_awaddr[9:2] == 8'h73;
	wire logic       w74 = hs && s_axi_awaddr[9:2] == 8'h74;
	wire logic       w75 = hs && s_axi_awaddr[9:2] == 8'h75;
	wire logic [7:0] d   = s_axi_wdata[7:0];
	wire logic       dyn = ctrl.dynamic_channel_power;

	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// ****************************************
	// Properties
	// ****************************************
	AST_IN_ONE: assert property (w73 |-> ##2 ctrl.input_one_on == $past(d[7], 2))
		else $error("input one enable mismatch");
	AST_IN_TWO: assert property (w73 |-> ##2 ctrl.input_two_on == $past(d[6], 2))
		else $error("input two enable mismatch");
	AST_SLOT_ONE: assert property (w74 |-> ##2 ctrl.serial_slot_one_on == $past(d[7], 2))
		else $error("slot one enable mismatch");
	AST_SLOT_TWO: assert property (w74 |-> ##2 ctrl.serial_slot_two_on == $past(d[6], 2))
		else $error("slot two enable mismatch");
	AST_BIAS: assert property (w75 |-> ##2 ctrl.mic_bias_power == $past(d[7], 2))
		else $error("bias power mismatch");
	AST_LOOP: assert property (w75 |-> ##2 ctrl.loop_power == $past(d[5], 2))
		else $error("loop power mismatch");
	AST_CONV_OFF: assert property (w75 && !d[6] |-> ##[2:3] !(ctrl.ch_one_power || ctrl.ch_two_power))
		else $error("channels not powered down");
	AST_STATIC: assert property (w73 && !dyn && ctrl.ch_one_power && !ctrl.ch_two_power
		|-> ##1 !ctrl.ch_two_power [*3]) else $error("channel two changed while recording");
	AST_DYN: assert property (w73 && dyn && ctrl.ch_one_power
		|-> ##3 ctrl.ch_two_power == $past(d[6], 3)) else $error("channel two did not follow");
	AST_RESET: assert property ($fell(rst) |-> ##1 ctrl == 9'h180)
		else $error("control reset value wrong");
endmodule

bind cepc_regs cepc_regs_assertions cepc_regs_assertions_inst
(
	.clk_sys       (clk_sys),
	.rst           (rst),
	.s_axi_awvalid (s_axi_awvalid),
	.s_axi_awready (s_axi_awready),
	.s_axi_awaddr  (s_axi_awaddr),
	.s_axi_wvalid  (s_axi_wvalid),
	.s_axi_wready  (s_axi_wready),
	.s_axi_wdata   (s_axi_wdata),
	.s_axi_wstrb   (s_axi_wstrb),
	.ctrl          (ctrl)
);

// ===== bench/cepc_regs_bench.sv
/*
 * Self-checking bench for the register bank over AXI4-Lite.
 * Assumes the design package is compiled first.
 */
module cepc_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 clk_sys = 0, rst = 1;
	logic                 s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic                 s_axi_arvalid = 0, s_axi_rready = 0;
	logic [9:0]           s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]          s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]           s_axi_wstrb = 4'hF;
	logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]           s_axi_bresp, s_axi_rresp;
	cepc_pkg::cepc_ctrl_s ctrl;
	int                   err_count = 0, comparisons = 0;

	always #2.5 clk_sys = ~clk_sys;
	cepc_regs cepc_regs_inst
	(
		.clk_sys       (clk_sys),
		.rst           (rst),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.ctrl          (ctrl)
	);

	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task automatic chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] i, v, input logic [1:0] r);
		logic ta, tw, tb;
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(negedge clk_sys) {ta, tw, tb} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
			if (tb) chk("bresp", {30'h0, s_axi_bresp}, {30'h0, r});
			@(posedge clk_sys) if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
		end while (!tb);
		s_axi_bready <= 1'h0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] i, v, input logic [1:0] r);
		logic ta, tv;
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(negedge clk_sys) {ta, tv} = {s_axi_arready, s_axi_rvalid};
			if (tv) chk("rdata", s_axi_rdata, {24'h0, v});
			if (tv) chk("rresp", {30'h0, s_axi_rresp}, {30'h0, r});
			@(posedge clk_sys) if (ta) s_axi_arvalid <= 1'h0;
		end while (!tv);
		s_axi_rready <= 1'h0;
		@(posedge clk_sys);
	endtask
	task automatic cc(input logic [8:0] e);
		repeat (4) @(negedge clk_sys);
		chk("ctrl", {23'h0, ctrl}, {23'h0, e});
		@(posedge clk_sys);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		cc(9'h180);
		rd(8'h73, 8'hFC, 2'h0);
		rd(8'h74, 8'h00, 2'h0);
		rd(8'h75, 8'h00, 2'h0);
		rd(8'h76, 8'h00, 2'h0);
		rd(8'h10, 8'h00, 2'h2);
		wr(8'h10, 8'hFF, 2'h2);
		cc(9'h180);
	endtask
	task automatic t_fields();
		s_axi_wstrb <= 4'hE;
		wr(8'h73, 8'h3C, 2'h0);
		s_axi_wstrb <= 4'hF;
		rd(8'h73, 8'hFC, 2'h0);
		wr(8'h73, 8'h7C, 2'h0);
		cc(9'h080);
		wr(8'h73, 8'hBC, 2'h0);
		cc(9'h100);
		wr(8'h74, 8'h80, 2'h0);
		cc(9'h140);
		wr(8'h74, 8'h40, 2'h0);
		cc(9'h120);
		wr(8'h75, 8'hA0, 2'h0);
		cc(9'h138);
		rd(8'h75, 8'hA0, 2'h0);
		wr(8'h75, 8'h00, 2'h0);
	endtask
	task automatic t_static();
		wr(8'h75, 8'h40, 2'h0);
		cc(9'h122);
		wr(8'h73, 8'hFC, 2'h0);
		cc(9'h1A2);
		rd(8'h76, 8'h80, 2'h0);
		wr(8'h76, 8'h00, 2'h0);
		rd(8'h76, 8'h80, 2'h0);
	endtask
	task automatic t_dyn();
		wr(8'h75, 8'h50, 2'h0);
		cc(9'h1A7);
		wr(8'h73, 8'hBC, 2'h0);
		cc(9'h126);
		wr(8'h75, 8'h00, 2'h0);
		cc(9'h120);
	endtask
	task automatic t_rerst();
		wr(8'h74, 8'hC0, 2'h0);
		rst <= 1'h1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'h0;
		@(posedge clk_sys);
		cc(9'h180);
		rd(8'h73, 8'hFC, 2'h0);
		rd(8'h74, 8'h00, 2'h0);
		rd(8'h75, 8'h00, 2'h0);
	endtask
	task automatic summarize();
		if (err_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'h0;
		@(posedge clk_sys);
		t_reset();
		t_fields();
		t_static();
		t_dyn();
		t_rerst();
		summarize();
	end
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		err_count++;
		summarize();
	end
endmodule

// ===== hw/cepc_pkg.sv
/*
 * Package for the channel enable and power configuration register bank:
 * register indices, field positions, reset values and shared structs.
 * Assumes a single clock domain and an AXI4-Lite master with 32-bit data.
 */
package cepc_pkg;

	// ****************************************
	// Register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [7:0] IDX_INPUT_CHANNEL_ENABLE      = 8'h73;
	localparam logic [7:0] IDX_SERIAL_OUTPUT_SLOT_ENABLE = 8'h74;
	localparam logic [7:0] IDX_POWER_CONFIGURATION       = 8'h75;
	localparam logic [7:0] IDX_DEVICE_STATUS_ZERO        = 8'h76;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_INPUT_CHANNEL_ENABLE      = 8'hFC;
	localparam logic [7:0] RST_SERIAL_OUTPUT_SLOT_ENABLE = 8'h00;
	localparam logic [7:0] RST_POWER_CONFIGURATION       = 8'h00;
	localparam logic [7:0] RST_DEVICE_STATUS_ZERO        = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_CH_ONE       = 7;
	localparam int BIT_CH_TWO       = 6;
	localparam int BIT_MIC_BIAS     = 7;
	localparam int BIT_CONVERTER    = 6;
	localparam int BIT_LOOP         = 5;
	localparam int BIT_DYNAMIC      = 4;
	// Power register bit 0 is read-only zero
	localparam logic [7:0] PWR_WRITE_MASK = 8'hFE;

	// ****************************************
	// AXI response codes
	// ****************************************
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Channel enable, slot enable and power controls driven into the analog side and serial port
	typedef struct packed {
		logic input_one_on;
		logic input_two_on;
		logic serial_slot_one_on;
		logic serial_slot_two_on;
		logic mic_bias_power;
		logic loop_power;
		logic dynamic_channel_power;
		logic ch_one_power;
		logic ch_two_power;
	} cepc_ctrl_s;

endpackage

// ===== hw/cepc_regs.sv
/*
 * Channel enable and power configuration register bank, AXI4-Lite slave.
 * Assumes clk_sys at 200 MHz, synchronous active-high rst, one master.
 */
module cepc_regs
(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// AXI4-Lite write address and data
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [9:0]        s_axi_awaddr,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	// AXI4-Lite write response
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	// AXI4-Lite read
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [9:0]        s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	// Analog and serial-port controls
	output cepc_pkg::cepc_ctrl_s   ctrl
);

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0]           in_en_q;
	logic [7:0]           slot_en_q;
	logic [7:0]           pwr_q;
	logic                 ch1_pwr_q;
	logic                 ch2_pwr_q;
	logic                 aw_hold_q;
	logic                 w_hold_q;
	logic                 awready_q;
	logic                 wready_q;
	logic                 arready_q;
	logic [9:0]           awaddr_q;
	logic [31:0]          wdata_q;
	logic                 wstrb0_q;
	logic                 bvalid_q;
	logic [1:0]           bresp_q;
	logic                 rvalid_q;
	logic [31:0]          rdata_q;
	logic [1:0]           rresp_q;
	cepc_pkg::cepc_ctrl_s ctrl_q;

	function automatic logic [7:0] idx_of(input logic [9:0] addr);
		idx_of = addr[9:2];
	endfunction

	function automatic logic idx_mapped(input logic [7:0] idx);
		idx_mapped = (idx >= cepc_pkg::IDX_INPUT_CHANNEL_ENABLE)
			&& (idx <= cepc_pkg::IDX_DEVICE_STATUS_ZERO);
	endfunction

	// Response code shared by the write and read paths
	function automatic logic [1:0] resp_for(input logic [7:0] idx);
		resp_for = idx_mapped(idx) ? cepc_pkg::RESP_OKAY : cepc_pkg::RESP_SLVERR;
	endfunction

	// ****************************************
	// Write channel
	// ****************************************
	// Only a handshaken channel counts, so a refused offer is never held
	wire        aw_take   = s_axi_awvalid & awready_q;
	wire        w_take    = s_axi_wvalid & wready_q;
	wire        aw_have   = aw_hold_q | aw_take;
	wire        w_have    = w_hold_q | w_take;
	wire        wr_fire   = aw_have & w_have & ~bvalid_q;
	wire [9:0]  wr_addr   = aw_hold_q ? awaddr_q : s_axi_awaddr;
	wire [31:0] wr_data   = w_hold_q ? wdata_q : s_axi_wdata;
	wire        wr_lane0  = w_hold_q ? wstrb0_q : s_axi_wstrb[0];
	wire [7:0]  wr_idx    = idx_of(wr_addr);
	wire        wr_commit = wr_fire & wr_lane0;
	wire        we_in     = wr_commit && (wr_idx == cepc_pkg::IDX_INPUT_CHANNEL_ENABLE);
	wire        we_slot   = wr_commit && (wr_idx == cepc_pkg::IDX_SERIAL_OUTPUT_SLOT_ENABLE);
	wire        we_pwr    = wr_commit && (wr_idx == cepc_pkg::IDX_POWER_CONFIGURATION);
	wire [7:0]  pwr_wr    = wr_data[7:0] & cepc_pkg::PWR_WRITE_MASK;
	// Next state of the write side, shared by its flops and the readies
	wire        aw_hold_d = aw_have & ~wr_fire;
	wire        w_hold_d  = w_have & ~wr_fire;
	wire        bvalid_d  = wr_fire | (bvalid_q & ~s_axi_bready);
	wire        awready_d = ~aw_hold_d & ~bvalid_d;
	wire        wready_d  = ~w_hold_d & ~bvalid_d;
	wire [1:0]  bresp_d   = resp_for(wr_idx);

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	// Hold flags keep a half-offered write until its partner arrives
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
		end
		else
		begin
			aw_hold_q <= aw_hold_d;
			w_hold_q  <= w_hold_d;
		end
	end

	// Readies precomputed one cycle ahead so the bus sees plain flops
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
		end
		else
		begin
			awready_q <= awready_d;
			wready_q  <= wready_d;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			awaddr_q <= 10'h000;
		else if (aw_take)
			awaddr_q <= s_axi_awaddr;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			wdata_q  <= 32'h00000000;
			wstrb0_q <= 1'b0;
		end
		else if (w_take)
		begin
			wdata_q  <= s_axi_wdata;
			wstrb0_q <= s_axi_wstrb[0];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= cepc_pkg::RESP_OKAY;
		end
		else
		begin
			bvalid_q <= bvalid_d;
			if (wr_fire)
				bresp_q <= bresp_d;
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	// Reserved bits other than power bit 0 are stored as written; host keeps them at reset value
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			in_en_q   <= cepc_pkg::RST_INPUT_CHANNEL_ENABLE;
			slot_en_q <= cepc_pkg::RST_SERIAL_OUTPUT_SLOT_ENABLE;
			pwr_q     <= cepc_pkg::RST_POWER_CONFIGURATION;
		end
		else
		begin
			if (we_in)
				in_en_q <= wr_data[7:0];
			if (we_slot)
				slot_en_q <= wr_data[7:0];
			if (we_pwr)
				pwr_q <= pwr_wr;
		end
	end

	// ****************************************
	// Channel power sequencing
	// ****************************************
	wire conv_on   = pwr_q[cepc_pkg::BIT_CONVERTER];
	wire dyn_mode  = pwr_q[cepc_pkg::BIT_DYNAMIC];
	wire want1     = conv_on & in_en_q[cepc_pkg::BIT_CH_ONE];
	wire want2     = conv_on & in_en_q[cepc_pkg::BIT_CH_TWO];
	wire recording = ch1_pwr_q | ch2_pwr_q;
	// Static mode: change only from all-off or to all-off
	wire group_ok  = ~recording | ~conv_on;
	wire upd1      = dyn_mode | group_ok;
	wire upd2      = dyn_mode | group_ok;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ch1_pwr_q <= 1'b0;
			ch2_pwr_q <= 1'b0;
		end
		else
		begin
			if (upd1)
				ch1_pwr_q <= want1;
			if (upd2)
				ch2_pwr_q <= want2;
		end
	end

	// ****************************************
	// Control outputs
	// ****************************************
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			ctrl_q <= '0;
		else
		begin
			ctrl_q.input_one_on          <= in_en_q[cepc_pkg::BIT_CH_ONE];
			ctrl_q.input_two_on          <= in_en_q[cepc_pkg::BIT_CH_TWO];
			ctrl_q.serial_slot_one_on    <= slot_en_q[cepc_pkg::BIT_CH_ONE];
			ctrl_q.serial_slot_two_on    <= slot_en_q[cepc_pkg::BIT_CH_TWO];
			ctrl_q.mic_bias_power        <= pwr_q[cepc_pkg::BIT_MIC_BIAS];
			ctrl_q.loop_power            <= pwr_q[cepc_pkg::BIT_LOOP];
			ctrl_q.dynamic_channel_power <= dyn_mode;
			ctrl_q.ch_one_power          <= ch1_pwr_q;
			ctrl_q.ch_two_power          <= ch2_pwr_q;
		end
	end
	assign ctrl = ctrl_q;

	// ****************************************
	// Read channel
	// ****************************************
	wire [7:0] rd_idx = idx_of(s_axi_araddr);
	wire [7:0] status = {ch1_pwr_q, ch2_pwr_q, 6'h00};
	wire [7:0] rd_val =
		(rd_idx == cepc_pkg::IDX_INPUT_CHANNEL_ENABLE)      ? in_en_q   :
		(rd_idx == cepc_pkg::IDX_SERIAL_OUTPUT_SLOT_ENABLE) ? slot_en_q :
		(rd_idx == cepc_pkg::IDX_POWER_CONFIGURATION)       ? pwr_q     :
		(rd_idx == cepc_pkg::IDX_DEVICE_STATUS_ZERO)        ? status    : 8'h00;

	wire       rd_take  = s_axi_arvalid & arready_q;
	wire       rvalid_d = rd_take | (rvalid_q & ~s_axi_rready);

	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// Address ready tracks the inverse of the next read valid
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
		else
		begin
			rvalid_q  <= rvalid_d;
			arready_q <= ~rvalid_d;
		end
	end

	// Read data captured once per request, stands until taken
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			rdata_q <= 32'h00000000;
			rresp_q <= cepc_pkg::RESP_OKAY;
		end
		else if (rd_take)
		begin
			rdata_q <= {24'h000000, rd_val};
			rresp_q <= resp_for(rd_idx);
		end
	end

endmodule
